//--- inc/branch_pkg.sv
// Shared constants and types for the relative branch unit
// Contract
// RQ1: The displacement is the 16-bit offset field shifted left two places, sign-extended to 32 bits.
// RQ2: The target is the delay-slot address plus the sign-extended displacement.
// RQ3: A taken branch redirects the program counter only after the delay-slot instruction.
// RQ4: The unconditional idiom is branch_equal with both sources register zero, always taken.
// RQ5: The link idiom is major_opcode_a, source 00000, selector 10001, with a 16-bit offset.
// RQ6: The link idiom writes register 31 with the address of the second instruction after it.
// RQ7: Software must not name register 31 as the source of a linking branch.
// RQ8: Software must not put a branch, jump, exception return or wait in a delay slot.
// RQ9: Float branches use opcode 010001, sub-field 01000, selector 20..18, nullify 17, sense 16.
// RQ10: With the sense flag at 0 the branch is taken only when the selected condition bit is 0.
// RQ11: With the sense flag at 1 the branch is taken only when the selected condition bit is 1.
// RQ12: In the likely form the delay slot is nullified when the branch is not taken.
// RQ13: Eight condition bits are held and selected by the selector, set by float compares.
// RQ14: Condition bits change only through the float compare instruction.
// RQ15: Float branches may raise unusable, reserved and unimplemented exceptions; idioms none.
// RQ16: Target and condition are formed in the branch cycle and applied in the next slot.
package branch_pkg;
	localparam int unsigned XLEN          = 32;
	localparam int unsigned COND_NUM      = 8;
	localparam logic [5:0]  OP_BRANCH_EQUAL   = 6'h04;
	localparam logic [5:0]  OP_MAJOR_A        = 6'h01;
	localparam logic [5:0]  OP_FLOAT_COPROC   = 6'h11;
	localparam logic [4:0]  SEL_NONNEG_LINK   = 5'h11;
	localparam logic [4:0]  SUB_FP_BRANCH     = 5'h08;
	localparam logic [4:0]  REG_ZERO          = 5'h00;
	localparam logic [4:0]  REG_LINK          = 5'h1F;
	// Instruction field positions
	localparam int unsigned OPC_HI      = 31;
	localparam int unsigned OPC_LO      = 26;
	localparam int unsigned RS_HI       = 25;
	localparam int unsigned RS_LO       = 21;
	localparam int unsigned RT_HI       = 20;
	localparam int unsigned RT_LO       = 16;
	localparam int unsigned COND_SEL_HI = 20;
	localparam int unsigned COND_SEL_LO = 18;
	localparam int unsigned NULLIFY_BIT = 17;
	localparam int unsigned SENSE_BIT   = 16;
	localparam int unsigned OFF_HI      = 15;
	localparam int unsigned SEXT_W      = 14;
	localparam logic [31:0] SLOT_STEP = 32'h0000_0004;
	localparam logic [31:0] LINK_STEP = 32'h0000_0008;
	// Register map (byte addresses)
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ADDR_MASK   = 8'h08;
	localparam logic [7:0]  ADDR_TARGET = 8'h0C;
	localparam logic [7:0]  ADDR_COND   = 8'h10;
	localparam logic [7:0]  ADDR_LINK   = 8'h14;
	localparam int unsigned CTRL_W      = 3;
	localparam int unsigned CTRL_USABLE = 0;
	localparam int unsigned CTRL_PRESENT = 1;
	localparam int unsigned CTRL_TRAP   = 2;
	localparam logic [2:0]  CTRL_RESET  = 3'h3;
	localparam int unsigned EV_W        = 5;
	localparam int unsigned EV_TAKEN    = 0;
	localparam int unsigned EV_NULLIFY  = 1;
	localparam int unsigned EV_UNUSABLE = 2;
	localparam int unsigned EV_RESERVED = 3;
	localparam int unsigned EV_UNIMPL   = 4;
	localparam logic [4:0]  EV_RESET    = 5'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		KIND_NONE   = 2'h0,
		KIND_UNCOND = 2'h1,
		KIND_LINK   = 2'h3,
		KIND_FP     = 2'h2
	} branch_kind_type;
	typedef enum logic [0:0] {
		ST_IDLE = 1'h0,
		ST_SLOT = 1'h1
	} seq_state_type;
	typedef enum logic [2:0] {
		REG_CTRL_SEL   = 3'h0,
		REG_STATUS_SEL = 3'h1,
		REG_MASK_SEL   = 3'h2,
		REG_TARGET_SEL = 3'h3,
		REG_COND_SEL   = 3'h4,
		REG_LINK_SEL   = 3'h5,
		REG_NONE_SEL   = 3'h7
	} reg_sel_type;
endpackage : branch_pkg

//--- rtl/branch_decode.sv
// Instruction classifier and target arithmetic for the branch group
`timescale 1ns/100ps
module branch_decode (
	// Instruction under decode
	input  wire logic [31:0]                  instr,
	input  wire logic [31:0]                  pc,
	// Decoded fields
	output branch_pkg::branch_kind_type       kind,
	output logic      [2:0]                   fp_cond_select,
	output logic                              nullify_flag,
	output logic                              sense_flag,
	output logic      [31:0]                  target,
	output logic      [31:0]                  link_value
);
	logic [31:0] disp;

	function automatic branch_pkg::branch_kind_type classify(input logic [31:0] w);
		logic [5:0] opc;
		logic [4:0] rs;
		logic [4:0] rt;
		opc = w[branch_pkg::OPC_HI:branch_pkg::OPC_LO];
		rs  = w[branch_pkg::RS_HI:branch_pkg::RS_LO];
		rt  = w[branch_pkg::RT_HI:branch_pkg::RT_LO];
		if (opc == branch_pkg::OP_BRANCH_EQUAL && rs == branch_pkg::REG_ZERO
				&& rt == branch_pkg::REG_ZERO) begin // RQ4
			return branch_pkg::KIND_UNCOND;
		end else if (opc == branch_pkg::OP_MAJOR_A && rs == branch_pkg::REG_ZERO
				&& rt == branch_pkg::SEL_NONNEG_LINK) begin // RQ5
			return branch_pkg::KIND_LINK;
		end else if (opc == branch_pkg::OP_FLOAT_COPROC
				&& rs == branch_pkg::SUB_FP_BRANCH) begin // RQ9
			return branch_pkg::KIND_FP;
		end else begin
			return branch_pkg::KIND_NONE;
		end
	endfunction : classify

	always_comb begin
		kind           = classify(instr);
		fp_cond_select = instr[branch_pkg::COND_SEL_HI:branch_pkg::COND_SEL_LO]; // RQ9
		nullify_flag   = instr[branch_pkg::NULLIFY_BIT];
		sense_flag     = instr[branch_pkg::SENSE_BIT];
		// Offset with two zero bits, sign-extended from bit 17
		disp = {{branch_pkg::SEXT_W{instr[branch_pkg::OFF_HI]}},
			instr[branch_pkg::OFF_HI:0], 2'h0}; // RQ1
		target     = pc + branch_pkg::SLOT_STEP + disp; // RQ2
		link_value = pc + branch_pkg::LINK_STEP; // RQ6
	end
endmodule : branch_decode

//--- rtl/fp_cond_bank.sv
// Eight floating-point condition bits written by compares
`timescale 1ns/100ps
module fp_cond_bank (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Compare result port
	input  wire logic        cmp_valid,
	input  wire logic [2:0]  cmp_sel,
	input  wire logic        cmp_value,
	// Branch test port
	input  wire logic [2:0]  rd_sel,
	output logic             rd_bit,
	output logic [7:0]       all_bits
);
	typedef struct packed {
		logic [7:0] bits;
	} bank_type;

	bank_type q;
	bank_type d;

	always_comb begin
		d = q;
		// Only a compare may change a condition bit
		if (cmp_valid) begin
			d.bits[cmp_sel] = cmp_value; // RQ14
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rd_bit   = q.bits[rd_sel]; // RQ13
	assign all_bits = q.bits;
endmodule : fp_cond_bank

//--- rtl/branch_unit.sv
// Relative branch unit with delay-slot sequencing and AXI4-Lite registers
`timescale 1ns/100ps
module branch_unit (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Instruction stream from fetch
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr_word,
	input  wire logic [31:0] instr_pc,
	// Float compare results
	input  wire logic        fp_cmp_valid,
	input  wire logic [2:0]  fp_cmp_sel,
	input  wire logic        fp_cmp_value,
	// Program counter redirect and slot control
	output logic             redirect_valid,
	output logic [31:0]      redirect_pc,
	output logic             nullify_slot,
	// Link register write
	output logic             link_we,
	output logic [4:0]       link_reg,
	output logic [31:0]      link_data,
	// Exceptions
	output logic             exc_cop_unusable,
	output logic             exc_reserved,
	output logic             exc_fp_unimpl,
	output logic             irq,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);
	// Unit state apart from the condition bits in u_cond, registered as one word
	typedef struct packed {
		// Delay-slot sequencer
		branch_pkg::seq_state_type st;
		logic                      taken;
		logic                      likely;
		logic [31:0]               target;
		// One-cycle pulses and held outputs
		logic                      redirect;
		logic [31:0]               redirect_pc;
		logic                      nullify;
		logic                      link_we;
		logic [31:0]               link_data;
		logic                      exc_unusable;
		logic                      exc_reserved;
		logic                      exc_unimpl;
		// Software-visible registers
		logic [2:0]                ctrl;
		logic [4:0]                status;
		logic [4:0]                mask;
		logic [31:0]               last_target;
		// Bus responses
		logic                      bvalid;
		logic [1:0]                bresp;
		logic                      rvalid;
		logic [31:0]               rdata;
		logic [1:0]                rresp;
	} unit_type;

	unit_type                    q;
	unit_type                    d;
	branch_pkg::branch_kind_type kind;
	logic [2:0]                  fp_cond_select;
	logic                        nullify_flag;
	logic                        sense_flag;
	logic [31:0]                 target;
	logic [31:0]                 link_value;
	logic                        cond_bit;
	logic [7:0]                  cond_bits;
	logic [4:0]                  events;
	logic                        wr_fire;
	logic                        rd_fire;
	branch_pkg::reg_sel_type     wsel;
	branch_pkg::reg_sel_type     rsel;

	// Shared by the write and read paths
	function automatic branch_pkg::reg_sel_type reg_decode(input logic [7:0] a);
		case (a)
			branch_pkg::ADDR_CTRL:   return branch_pkg::REG_CTRL_SEL;
			branch_pkg::ADDR_STATUS: return branch_pkg::REG_STATUS_SEL;
			branch_pkg::ADDR_MASK:   return branch_pkg::REG_MASK_SEL;
			branch_pkg::ADDR_TARGET: return branch_pkg::REG_TARGET_SEL;
			branch_pkg::ADDR_COND:   return branch_pkg::REG_COND_SEL;
			branch_pkg::ADDR_LINK:   return branch_pkg::REG_LINK_SEL;
			default:                 return branch_pkg::REG_NONE_SEL;
		endcase
	endfunction : reg_decode

	branch_decode u_decode (
		.instr          (instr_word),
		.pc             (instr_pc),
		.kind           (kind),
		.fp_cond_select (fp_cond_select),
		.nullify_flag   (nullify_flag),
		.sense_flag     (sense_flag),
		.target         (target),
		.link_value     (link_value)
	);

	// The bank is read with the selector of the word under decode
	fp_cond_bank u_cond (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.cmp_valid (fp_cmp_valid),
		.cmp_sel   (fp_cmp_sel),
		.cmp_value (fp_cmp_value),
		.rd_sel    (fp_cond_select),
		.rd_bit    (cond_bit),
		.all_bits  (cond_bits)
	);

	// Both write channels are taken in one edge; holding ready low until both arrive
	// is legal and avoids buffering a lone address or data beat.
	assign wr_fire = awvalid && wvalid && !q.bvalid;
	assign rd_fire = arvalid && !q.rvalid;
	assign wsel    = reg_decode(awaddr);
	assign rsel    = reg_decode(araddr);

	always_comb begin
		d          = q;

		// Pulses last one cycle unless raised again below
		d.redirect = 1'b0;
		d.nullify  = 1'b0;
		d.link_we  = 1'b0;
		d.exc_unusable = 1'b0;
		d.exc_reserved = 1'b0;
		d.exc_unimpl   = 1'b0;

		case (q.st)
			branch_pkg::ST_IDLE: begin
				if (instr_valid && kind != branch_pkg::KIND_NONE) begin
					// Unusable unit first, then absent unit, then the trap
					if (kind == branch_pkg::KIND_FP
							&& !q.ctrl[branch_pkg::CTRL_USABLE]) begin
						d.exc_unusable = 1'b1; // RQ15
					end else if (kind == branch_pkg::KIND_FP
							&& !q.ctrl[branch_pkg::CTRL_PRESENT]) begin
						d.exc_reserved = 1'b1; // RQ15
					end else if (kind == branch_pkg::KIND_FP
							&& q.ctrl[branch_pkg::CTRL_TRAP]) begin
						d.exc_unimpl = 1'b1; // RQ15
					end else begin
						// Condition and target are latched now, used at the slot
						d.st     = branch_pkg::ST_SLOT; // RQ16
						d.target = target;
						if (kind == branch_pkg::KIND_FP) begin
							d.taken  = (cond_bit == sense_flag); // RQ10 RQ11
							d.likely = nullify_flag;
						end else begin
							d.taken  = 1'b1; // RQ4
							d.likely = 1'b0;
						end
						if (kind == branch_pkg::KIND_LINK) begin
							d.link_we   = 1'b1; // RQ6
							d.link_data = link_value;
						end
					end
				end
			end
			branch_pkg::ST_SLOT: begin
				// The slot instruction goes by first; a branch placed here is not decoded
				if (instr_valid) begin // RQ8
					d.st          = branch_pkg::ST_IDLE;
					d.redirect    = q.taken; // RQ3
					d.redirect_pc = q.target;
					d.nullify     = q.likely && !q.taken; // RQ12
					if (q.taken) begin
						d.last_target = q.target;
					end
				end
			end
			default: begin
				d.st = branch_pkg::ST_IDLE;
			end
		endcase

		// Event pulses feed the sticky status bits
		events                          = '0;
		events[branch_pkg::EV_TAKEN]    = d.redirect;
		events[branch_pkg::EV_NULLIFY]  = d.nullify;
		events[branch_pkg::EV_UNUSABLE] = d.exc_unusable;
		events[branch_pkg::EV_RESERVED] = d.exc_reserved;
		events[branch_pkg::EV_UNIMPL]   = d.exc_unimpl;

		// One write at a time; the next is taken once bready frees the response
		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			d.bvalid = 1'b1;
			d.bresp  = branch_pkg::RESP_OKAY;
			case (wsel)
				branch_pkg::REG_CTRL_SEL: begin
					if (wstrb[0]) begin
						d.ctrl = wdata[branch_pkg::CTRL_W-1:0];
					end
				end
				branch_pkg::REG_STATUS_SEL: begin
					if (wstrb[0]) begin
						d.status = q.status & ~wdata[branch_pkg::EV_W-1:0];
					end
				end
				branch_pkg::REG_MASK_SEL: begin
					if (wstrb[0]) begin
						d.mask = wdata[branch_pkg::EV_W-1:0];
					end
				end
				branch_pkg::REG_TARGET_SEL, branch_pkg::REG_COND_SEL,
				branch_pkg::REG_LINK_SEL: begin
					d.bresp = branch_pkg::RESP_OKAY;
				end
				default: begin
					d.bresp = branch_pkg::RESP_SLVERR;
				end
			endcase
		end

		// A new event wins over a clear in the same cycle
		d.status = d.status | events;

		// Read data are registered and stand unchanged while rvalid waits
		if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
		end
		if (rd_fire) begin
			d.rvalid = 1'b1;
			d.rresp  = branch_pkg::RESP_OKAY;
			d.rdata  = '0;
			case (rsel)
				branch_pkg::REG_CTRL_SEL: begin
					d.rdata[branch_pkg::CTRL_W-1:0] = q.ctrl;
				end
				branch_pkg::REG_STATUS_SEL: begin
					d.rdata[branch_pkg::EV_W-1:0] = q.status;
				end
				branch_pkg::REG_MASK_SEL: begin
					d.rdata[branch_pkg::EV_W-1:0] = q.mask;
				end
				branch_pkg::REG_TARGET_SEL: begin
					d.rdata = q.last_target;
				end
				branch_pkg::REG_COND_SEL: begin
					d.rdata[7:0] = cond_bits;
				end
				branch_pkg::REG_LINK_SEL: begin
					d.rdata = q.link_data;
				end
				default: begin
					d.rresp = branch_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q        <= '0;
			q.st     <= branch_pkg::ST_IDLE;
			q.ctrl   <= branch_pkg::CTRL_RESET;
			q.status <= branch_pkg::EV_RESET;
			q.mask   <= branch_pkg::EV_RESET;
		end else begin
			q <= d;
		end
	end

	// Sequencer and exception outputs
	assign redirect_valid   = q.redirect;
	assign redirect_pc      = q.redirect_pc;
	assign nullify_slot     = q.nullify;
	assign link_we          = q.link_we;
	assign link_reg         = branch_pkg::REG_LINK;
	assign link_data        = q.link_data;
	assign exc_cop_unusable = q.exc_unusable;
	assign exc_reserved     = q.exc_reserved;
	assign exc_fp_unimpl    = q.exc_unimpl;
	assign irq              = |(q.status & q.mask);

	// Register bus handshakes and responses
	assign awready          = wr_fire;
	assign wready           = wr_fire;
	assign bvalid           = q.bvalid;
	assign bresp            = q.bresp;
	assign arready          = !q.rvalid;
	assign rvalid           = q.rvalid;
	assign rdata            = q.rdata;
	assign rresp            = q.rresp;
endmodule : branch_unit

//--- sim/branch_unit_props.sv
// Port-level checker for the relative branch unit
`timescale 1ns/100ps
module branch_unit_props (
	// Clock, reset, fetch and compare
	input wire logic		aclk,
	input wire logic		aresetn,
	input wire logic		instr_valid,
	input wire logic [31:0]	instr_word,
	input wire logic [31:0]	instr_pc,
	input wire logic		fp_cmp_valid,
	input wire logic [2:0]	fp_cmp_sel,
	input wire logic		fp_cmp_value,
	// Outputs under check
	input wire logic		redirect_valid,
	input wire logic [31:0]	redirect_pc,
	input wire logic		nullify_slot,
	input wire logic		link_we,
	input wire logic [4:0]	link_reg,
	input wire logic [31:0]	link_data,
	input wire logic		exc_cop_unusable,
	input wire logic		exc_reserved,
	input wire logic		exc_fp_unimpl
);
	logic			br_q, wait_q, f_q, nl_q, tk_q;
	logic [31:0]	tgt_q;
	logic [7:0]		cond_q;
	wire			exc = exc_cop_unusable | exc_reserved | exc_fp_unimpl;
	// A branch that excepts leaves no slot pending
	wire			pend = (br_q && !exc) || wait_q;
	wire			is_u = instr_word[31:16] == 16'h1000;
	wire			is_l = instr_word[31:16] == 16'h0411;
	wire			is_f = instr_word[31:21] == 11'h228;
	wire			br = instr_valid && !pend && (is_u || is_l || is_f);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Mirror of the condition bits; a compare lands one edge before a branch may test it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			br_q <= 1'h0;
			wait_q <= 1'h0;
			cond_q <= 8'h00;
		end else begin
			br_q <= br;
			wait_q <= pend && !instr_valid;
			if (fp_cmp_valid) cond_q[fp_cmp_sel] <= fp_cmp_value;
		end
		if (br) begin
			f_q <= is_f;
			nl_q <= instr_word[17];
			tk_q <= cond_q[instr_word[20:18]] == instr_word[16];
			tgt_q <= instr_pc + 32'h4 + {{14{instr_word[15]}}, instr_word[15:0], 2'h0};
		end
	end
	AST_LINK: assert property (br && is_l |=> link_we && link_reg == 5'h1F
		&& link_data == $past(instr_pc) + 32'h8) else $error("link write wrong");
	AST_NO_LINK: assert property (br && !is_l |=> !link_we)
		else $error("spurious link write");
	AST_IDIOM_QUIET: assert property (br && !is_f |=> !exc)
		else $error("idiom raised exception");
	AST_EXC_CAUSE: assert property (exc |-> br_q && f_q)
		else $error("exception without float branch");
	AST_AFTER_SLOT: assert property ((redirect_valid || nullify_slot) |->
		$past(pend) && $past(instr_valid)) else $error("redirect before delay slot");
	AST_UNCOND: assert property (pend && instr_valid && !f_q |=> redirect_valid)
		else $error("idiom not taken");
	AST_SENSE: assert property (pend && instr_valid && f_q |=> redirect_valid == tk_q)
		else $error("float condition sense wrong");
	AST_LIKELY: assert property (pend && instr_valid && f_q
		|=> nullify_slot == (nl_q && !tk_q)) else $error("delay slot nullify wrong");
	AST_TARGET: assert property (redirect_valid |-> redirect_pc == tgt_q)
		else $error("target wrong");
	cover property (redirect_valid);
	cover property (nullify_slot);
	cover property (link_we);
	cover property (exc);
endmodule : branch_unit_props
bind branch_unit branch_unit_props chk (.*);

//--- sim/fetch_model.sv
// Fetch stage and float compare model feeding the branch unit
`timescale 1ns/100ps
module fetch_model (
	// Clock
	input wire logic	aclk,
	// Instruction stream and compare results
	output logic		instr_valid,
	output logic [31:0]	instr_word,
	output logic [31:0]	instr_pc,
	output logic		fp_cmp_valid,
	output logic [2:0]	fp_cmp_sel,
	output logic		fp_cmp_value
);
	initial begin
		instr_valid = 1'h0;
		instr_word = 32'h0;
		instr_pc = 32'h0;
		fp_cmp_valid = 1'h0;
		fp_cmp_sel = 3'h0;
		fp_cmp_value = 1'h0;
	end
	// Idle lines flip so a stale word never looks like a held one
	task drive(input logic v, input logic [31:0] w, input logic [31:0] p, input logic cv,
		input logic [2:0] cs, input logic cb);
		@(posedge aclk);
		instr_valid <= v;
		instr_word <= v ? w : ~instr_word;
		instr_pc <= v ? p : ~instr_pc;
		fp_cmp_valid <= cv;
		fp_cmp_sel <= cv ? cs : ~fp_cmp_sel;
		fp_cmp_value <= cv ? cb : ~fp_cmp_value;
	endtask : drive
	task put(input logic [31:0] w, input logic [31:0] p);
		drive(1'h1, w, p, 1'h0, 3'h0, 1'h0);
	endtask : put
	task gap();
		drive(1'h0, 32'h0, 32'h0, 1'h0, 3'h0, 1'h0);
	endtask : gap
	task cmp(input logic [2:0] s, input logic b);
		drive(1'h0, 32'h0, 32'h0, 1'h1, s, b);
	endtask : cmp
endmodule : fetch_model

//--- sim/branch_unit_tb_top.sv
// Self-checking bench for the relative branch unit
`timescale 1ns/100ps
module branch_unit_tb_top;
	logic			aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]		awaddr, araddr;
	logic [31:0]	wdata, d;
	logic [3:0]		wstrb;
	logic [1:0]		rsp;
	int				mismatches, tests_run;
	wire			instr_valid, fp_cmp_valid, fp_cmp_value, redirect_valid, nullify_slot;
	wire			link_we, exc_cop_unusable, exc_reserved, exc_fp_unimpl, irq;
	wire			awready, wready, bvalid, arready, rvalid;
	wire [31:0]		instr_word, instr_pc, redirect_pc, link_data, rdata;
	wire [2:0]		fp_cmp_sel;
	wire [4:0]		link_reg;
	wire [1:0]		bresp, rresp;
	branch_unit dut (.*);
	fetch_model fetch (.*);
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task print_verdict();
		if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do @(posedge aclk); while (!(awready && wready));
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		do @(posedge aclk); while (!bvalid);
		rsp = bresp;
		bready <= 1'h0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		rsp = rresp;
		rready <= 1'h0;
	endtask : rd
	// Slot word is a plain non-branch; g stalls fetch one cycle before the slot
	task br_run(input logic [31:0] w, input logic [31:0] p, input logic tk, input logic nl,
		input logic lk, input logic g);
		fetch.put(w, p);
		if (g) fetch.gap();
		else fetch.put(32'h0, p + 32'h4);
		#1;
		chk(link_we, lk);
		chk({exc_cop_unusable, exc_reserved, exc_fp_unimpl}, 3'h0);
		if (lk) chk(link_data, p + 32'h8);
		if (g) begin
			fetch.put(32'h0, p + 32'h4);
			#1;
			chk(redirect_valid, 1'h0);
		end
		fetch.gap();
		#1;
		chk(redirect_valid, tk);
		chk(nullify_slot, nl);
		if (tk) chk(redirect_pc, p + 32'h4 + {{14{w[15]}}, w[15:0], 2'h0});
	endtask : br_run
	task t_regs();
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i));
			chk(d, i == 0 ? 32'h3 : 32'h0);
		end
		rd(8'h40);
		chk(rsp, branch_pkg::RESP_SLVERR);
		chk(d, 32'h0);
		wr(branch_pkg::ADDR_TARGET, 32'hFFFF_FFFF);
		chk(rsp, branch_pkg::RESP_OKAY);
		rd(branch_pkg::ADDR_TARGET);
		chk(d, 32'h0);
		wr(8'h44, 32'h1);
		chk(rsp, branch_pkg::RESP_SLVERR);
		chk({irq, link_reg}, 6'h1F);
	endtask : t_regs
	task t_idioms();
		// A branch_equal word with a live source is outside the group and opens no slot
		fetch.put(32'h1020_0004, 32'h500);
		fetch.put(32'h0, 32'h504);
		#1;
		chk({link_we, exc_cop_unusable, exc_reserved, exc_fp_unimpl}, 4'h0);
		fetch.gap();
		#1;
		chk({redirect_valid, nullify_slot}, 2'h0);
		br_run(32'h1000_8000, 32'h0000_1000, 1'h1, 1'h0, 1'h0, 1'h0);
		br_run(32'h0411_7FFF, 32'h0002_0000, 1'h1, 1'h0, 1'h1, 1'h1);
		rd(branch_pkg::ADDR_LINK);
		chk(d, 32'h0002_0008);
		rd(branch_pkg::ADDR_TARGET);
		chk(d, 32'h0004_0000);
	endtask : t_idioms
	task t_fp();
		logic [31:0] w;
		for (int i = 0; i < 8; i++) begin
			fetch.cmp(3'(i), i[2]);
			w = {6'h11, 5'h08, 3'(i), i[1], i[0], 16'hFFF0 + 16'(i)};
			br_run(w, 32'h100 + 32'(i * 16), i[2] == i[0], i[1] && i[2] != i[0], 1'h0, i[1]);
		end
		rd(branch_pkg::ADDR_COND);
		chk(d, 32'hF0);
	endtask : t_fp
	task t_exc();
		logic [2:0] c [3];
		logic [2:0] e [3];
		c = '{3'h1, 3'h7, 3'h0};
		e = '{3'h2, 3'h1, 3'h4};
		for (int i = 0; i < 3; i++) begin
			wr(branch_pkg::ADDR_CTRL, 32'(c[i]));
			fetch.put(32'h4501_0004, 32'h300);
			fetch.gap();
			#1;
			chk({exc_cop_unusable, exc_reserved, exc_fp_unimpl}, e[i]);
			fetch.gap();
			#1;
			chk(redirect_valid, 1'h0);
		end
		br_run(32'h0411_0002, 32'h400, 1'h1, 1'h0, 1'h1, 1'h0);
		wr(branch_pkg::ADDR_CTRL, 32'h3);
		rd(branch_pkg::ADDR_STATUS);
		chk(d, 32'h1F);
	endtask : t_exc
	task t_irq();
		wr(branch_pkg::ADDR_MASK, 32'h4);
		chk(irq, 1'h1);
		wr(branch_pkg::ADDR_STATUS, 32'h4);
		chk(irq, 1'h0);
		rd(branch_pkg::ADDR_STATUS);
		chk(d, 32'h1B);
		wr(branch_pkg::ADDR_STATUS, 32'h1F);
		rd(branch_pkg::ADDR_STATUS);
		chk(d, 32'h0);
	endtask : t_irq
	initial begin
		aclk = 1'h0;
		forever #50 aclk = ~aclk;
	end
	// Whole run needs about 140 cycles; 3000 leaves ample margin
	initial begin
		#300000;
		mismatches++;
		print_verdict();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_idioms();
		t_fp();
		t_exc();
		t_irq();
		print_verdict();
	end
endmodule : branch_unit_tb_top
